// >>> common/sigpin_params.svh
// Offsets, field positions, reset values and timing counts of the extended registers
`ifndef SIGPIN_PARAMS_SVH
`define SIGPIN_PARAMS_SVH
// ------------------------------------------------------------
// Register indexes within an extended-op transfer
// ------------------------------------------------------------
`define XR_IDX_PIN_DATA 3'h1
`define XR_IDX_PIN_DIR 3'h2
`define XR_IDX_THIRD_PIN 3'h3
`define XR_IDX_DEBOUNCE 3'h4
`define XR_IDX_COMMON 3'h5
`define XR_IDX_PCM 3'h6
`define XR_RESET 8'h00
// ------------------------------------------------------------
// Command byte fields
// ------------------------------------------------------------
`define OP_RST_BIT 7
`define OP_ZERO_BIT 6
`define OP_RW_BIT 5
`define OP_ONES_MSB 4
`define OP_ONES_LSB 3
`define OP_LSEL_MSB 2
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define XR3_DATA_LSB 4
`define XR4_N_LSB 4
`define XR4_T_LSB 0
`define XR5_MSEL_LSB 6
`define XR5_CRASH_A_BIT 5
`define XR5_CRASH_B_BIT 4
`define XR5_CHOP_LSB 2
`define XR5_VER_LSB 0
`define XR6_CMODE_BIT 7
`define XR6_XS_BIT 6
`define XR6_RS_BIT 5
`define XR6_DRV0_BIT 4
`define XR6_SHIFT_BIT 3
`define XR6_OFFS_LSB 0
// ------------------------------------------------------------
// Timing: master clock in kHz equals cycles per ms
// ------------------------------------------------------------
`define FK_1536 14'h0600
`define FK_2048 14'h0800
`define FK_4096 14'h1000
`define FK_8192 14'h2000
`define MS_PER_STEP 5'h02
`define CHOP_INC_512 14'h0400
`define CHOP_INC_256 14'h0200
`define PERIOD_HI_CODE 4'h0
`define PERIOD_LO_CODE 4'hf
`endif

// >>> common/sigpin_pkg.sv
// Types shared by the signaling pin and PCM configuration block
`default_nettype none
package sigpin_pkg;
	typedef enum logic [1:0] {
		MCLK_1536 = 2'b00,
		MCLK_2048 = 2'b01,
		MCLK_4096 = 2'b10,
		MCLK_8192 = 2'b11
	} mclk_sel_t;
	typedef enum logic [1:0] {
		CHOP_HIGH = 2'b00,
		CHOP_512K = 2'b01,
		CHOP_256K = 2'b10,
		CHOP_INTERNAL = 2'b11
	} chop_mode_t;
endpackage
`default_nettype wire

// >>> logic/signaling_pin_pcm_config.sv
// Extended registers: signaling pins, debounce, clocks, collision flags, PCM options
`include "sigpin_params.svh"
`default_nettype none
module signaling_pin_pcm_config import sigpin_pkg::*; #(
	parameter int SLOT_W = 7,
	parameter logic [13:0] MS_DIV_1536 = `FK_1536,
	parameter logic [13:0] MS_DIV_2048 = `FK_2048,
	parameter logic [13:0] MS_DIV_4096 = `FK_4096,
	parameter logic [13:0] MS_DIV_8192 = `FK_8192,
	parameter logic [1:0] VERSION_CODE = 2'h2 // Arbitrary value
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic op_valid,
	input wire logic [7:0] op_byte,
	input wire logic [1:0] chan_addr,
	input wire logic byte_strobe,
	input wire logic [7:0] byte_in,
	output logic [7:0] byte_out,
	output logic xfer_busy,
	input wire logic [11:0] bidir_signal_pin_in,
	output logic [11:0] bidir_signal_pin_out,
	output logic [11:0] bidir_signal_pin_oe,
	output logic irq_pair_low,
	output logic irq_pair_high,
	output logic slow_period_output,
	output logic chopper_clock_output,
	input wire logic [3:0] chan_powered,
	input wire logic [3:0] tx_active,
	input wire logic [3:0] tx_highway_b,
	input wire logic [4*SLOT_W-1:0] tx_slot,
	output logic [3:0] tx_inhibit,
	output sigpin_pkg::mclk_sel_t mclk_select,
	output logic [3:0] pcm_double_clock,
	output logic [3:0] pcm_tx_falling,
	output logic [3:0] pcm_rx_rising,
	output logic [3:0] pcm_first_bit_half,
	output logic [3:0] pcm_shift,
	output logic [11:0] pcm_slot_offset
);
	import sigpin_pkg::*;

	// ------------------------------------------------------------
	// Registers and transfer state
	// ------------------------------------------------------------
	logic [7:0] pin_data_ff, pin_dir_ff, third_pin_ff, debounce_ff, common_ff, byte_out_ff;
	logic [7:0] pcm_cfg_ff [4];
	logic xfer_active_ff, xfer_write_ff, rd1_seen_ff, rd3_seen_ff;
	logic [2:0] xfer_idx_ff;
	logic [1:0] xfer_chan_ff;
	logic [11:0] sync1_ff, sync2_ff, stable_ff;
	logic [4:0] db_cnt_ff [12];
	logic [13:0] ms_cnt_ff, chop_acc_ff;
	logic ms_tick, crash_a_ff, crash_b_ff, slow_ff, chop_ff, chop_fast_ff, irq_lo_ff, irq_hi_ff;
	logic [3:0] inhibit_ff, slow_cnt_ff;
	logic clr, op_ok, acc, wr_en, rd_en, rd_clear;
	logic [11:0] pin_data_all, pin_dir_all, readable, accept;
	logic [3:0] db_n, period_t, coll;
	logic [13:0] ms_div, chop_inc, nxt_chop_acc;

	function automatic logic [13:0] ms_cycles(input logic [1:0] sel);
		unique case (mclk_sel_t'(sel))
			MCLK_1536: ms_cycles = MS_DIV_1536;
			MCLK_2048: ms_cycles = MS_DIV_2048;
			MCLK_4096: ms_cycles = MS_DIV_4096;
			MCLK_8192: ms_cycles = MS_DIV_8192;
		endcase
	endfunction

	assign op_ok = op_valid && op_byte[`OP_ONES_MSB:`OP_ONES_LSB] == 2'b11 && !op_byte[`OP_ZERO_BIT];
	assign clr = rst || (ce && op_ok && op_byte[`OP_RST_BIT]);
	assign acc = ce && !op_ok && xfer_active_ff && byte_strobe;
	assign wr_en = acc && xfer_write_ff;
	assign rd_en = acc && !xfer_write_ff;
	assign pin_data_all = {third_pin_ff[7:`XR3_DATA_LSB], pin_data_ff};
	assign pin_dir_all = {third_pin_ff[3:0], pin_dir_ff};
	assign db_n = debounce_ff[`XR4_N_LSB+3:`XR4_N_LSB];
	assign period_t = debounce_ff[`XR4_T_LSB+3:`XR4_T_LSB];
	assign ms_div = ms_cycles(common_ff[`XR5_MSEL_LSB+1:`XR5_MSEL_LSB]);

	// ------------------------------------------------------------
	// Readable view: input pins show debounced level
	// ------------------------------------------------------------
	assign readable = (pin_dir_all & pin_data_all) | (~pin_dir_all & stable_ff);

	function automatic logic [7:0] reg_read(input logic [2:0] idx, input logic [1:0] ch);
		unique case (idx)
			`XR_IDX_PIN_DATA: reg_read = readable[7:0];
			`XR_IDX_PIN_DIR: reg_read = pin_dir_ff;
			`XR_IDX_THIRD_PIN: reg_read = {readable[11:8], third_pin_ff[3:0]};
			`XR_IDX_DEBOUNCE: reg_read = debounce_ff;
			`XR_IDX_COMMON: reg_read = {common_ff[7:6], crash_a_ff, crash_b_ff, common_ff[3:2], VERSION_CODE};
			`XR_IDX_PCM: reg_read = pcm_cfg_ff[ch];
			default: reg_read = `XR_RESET;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Extended-op transfer
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (clr) begin
			xfer_active_ff <= 1'b0;
			xfer_write_ff <= 1'b0;
			xfer_idx_ff <= 3'h0;
			xfer_chan_ff <= 2'h0;
			byte_out_ff <= `XR_RESET;
		end else if (ce) begin
			if (op_ok) begin
				xfer_active_ff <= 1'b1;
				xfer_write_ff <= !op_byte[`OP_RW_BIT];
				xfer_idx_ff <= op_byte[`OP_LSEL_MSB:0];
				xfer_chan_ff <= chan_addr;
			end else if (acc) begin
				if (!xfer_write_ff) begin
					byte_out_ff <= reg_read(xfer_idx_ff, xfer_chan_ff);
				end
				xfer_idx_ff <= xfer_idx_ff - 3'h1;
				xfer_active_ff <= xfer_idx_ff != 3'h0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (clr) begin
			pin_data_ff <= `XR_RESET;
			pin_dir_ff <= `XR_RESET;
			third_pin_ff <= `XR_RESET;
			debounce_ff <= `XR_RESET;
			common_ff <= `XR_RESET;
			for (int c = 0; c < 4; c++) begin
				pcm_cfg_ff[c] <= `XR_RESET;
			end
		end else if (wr_en) begin
			unique case (xfer_idx_ff)
				`XR_IDX_PIN_DATA: pin_data_ff <= byte_in;
				`XR_IDX_PIN_DIR: pin_dir_ff <= byte_in;
				`XR_IDX_THIRD_PIN: third_pin_ff <= byte_in;
				`XR_IDX_DEBOUNCE: debounce_ff <= byte_in;
				`XR_IDX_COMMON: common_ff <= byte_in;
				`XR_IDX_PCM: pcm_cfg_ff[xfer_chan_ff] <= byte_in;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pin synchroniser and debounce
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_ff <= 12'h000;
			sync2_ff <= 12'h000;
		end else if (ce) begin
			sync1_ff <= bidir_signal_pin_in;
			sync2_ff <= sync1_ff;
		end
	end

	always_ff @(posedge mclk) begin
		if (clr) begin
			ms_cnt_ff <= 14'h0000;
		end else if (ce) begin
			ms_cnt_ff <= ms_tick ? 14'h0000 : ms_cnt_ff + 14'h0001;
		end
	end
	assign ms_tick = ms_cnt_ff >= ms_div - 14'h0001;

	for (genvar i = 0; i < 12; i++) begin : g_db
		always_ff @(posedge mclk) begin
			if (clr) begin
				stable_ff[i] <= 1'b0;
				db_cnt_ff[i] <= 5'h00;
			end else if (ce) begin
				if (db_n == 4'h0) begin
					stable_ff[i] <= sync2_ff[i];
					db_cnt_ff[i] <= 5'h00;
				end else if (sync2_ff[i] == stable_ff[i]) begin
					db_cnt_ff[i] <= 5'h00;
				end else if (ms_tick) begin
					if (db_cnt_ff[i] + 5'h01 >= 5'(db_n) * `MS_PER_STEP) begin
						stable_ff[i] <= sync2_ff[i];
						db_cnt_ff[i] <= 5'h00;
					end else begin
						db_cnt_ff[i] <= db_cnt_ff[i] + 5'h01;
					end
				end
			end
		end
		assign accept[i] = ce && db_n != 4'h0 && !pin_dir_all[i] && db_cnt_ff[i] + 5'h01 >= 5'(db_n) * `MS_PER_STEP
			&& ms_tick && sync2_ff[i] != stable_ff[i];
	end

	// ------------------------------------------------------------
	// Pair interrupts
	// ------------------------------------------------------------
	assign rd_clear = (rd1_seen_ff || (rd_en && xfer_idx_ff == `XR_IDX_PIN_DATA))
		&& (rd3_seen_ff || (rd_en && xfer_idx_ff == `XR_IDX_THIRD_PIN));

	always_ff @(posedge mclk) begin
		if (clr) begin
			irq_lo_ff <= 1'b0;
			irq_hi_ff <= 1'b0;
			rd1_seen_ff <= 1'b0;
			rd3_seen_ff <= 1'b0;
		end else if (ce) begin
			irq_lo_ff <= |{accept[9:8], accept[3:0]} || (irq_lo_ff && !rd_clear);
			irq_hi_ff <= |{accept[11:10], accept[7:4]} || (irq_hi_ff && !rd_clear);
			rd1_seen_ff <= !rd_clear && (rd1_seen_ff || (rd_en && xfer_idx_ff == `XR_IDX_PIN_DATA));
			rd3_seen_ff <= !rd_clear && (rd3_seen_ff || (rd_en && xfer_idx_ff == `XR_IDX_THIRD_PIN));
		end
	end

	// ------------------------------------------------------------
	// Slow period and chopper outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (clr) begin
			slow_ff <= 1'b1;
			slow_cnt_ff <= 4'h0;
		end else if (ce) begin
			if (period_t == `PERIOD_HI_CODE) begin
				slow_ff <= 1'b1;
				slow_cnt_ff <= 4'h0;
			end else if (period_t == `PERIOD_LO_CODE) begin
				slow_ff <= 1'b0;
				slow_cnt_ff <= 4'h0;
			end else if (ms_tick) begin
				if (slow_cnt_ff + 4'h1 >= period_t) begin
					slow_ff <= !slow_ff;
					slow_cnt_ff <= 4'h0;
				end else begin
					slow_cnt_ff <= slow_cnt_ff + 4'h1;
				end
			end
		end
	end

	assign chop_inc = chop_mode_t'(common_ff[`XR5_CHOP_LSB+1:`XR5_CHOP_LSB]) == CHOP_512K ? `CHOP_INC_512
		: `CHOP_INC_256;
	assign nxt_chop_acc = chop_acc_ff + chop_inc;

	always_ff @(posedge mclk) begin
		if (clr) begin
			chop_acc_ff <= 14'h0000;
			chop_ff <= 1'b1;
			chop_fast_ff <= 1'b0;
		end else if (ce) begin
			chop_fast_ff <= !chop_fast_ff;
			unique case (chop_mode_t'(common_ff[`XR5_CHOP_LSB+1:`XR5_CHOP_LSB]))
				CHOP_HIGH: chop_ff <= 1'b1;
				CHOP_INTERNAL: chop_ff <= |chan_powered ? chop_fast_ff : 1'b1;
				CHOP_512K, CHOP_256K: begin
					if (nxt_chop_acc >= ms_div) begin
						chop_acc_ff <= nxt_chop_acc - ms_div;
						chop_ff <= !chop_ff;
					end else begin
						chop_acc_ff <= nxt_chop_acc;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Highway collision check
	// ------------------------------------------------------------
	for (genvar c = 0; c < 4; c++) begin : g_coll
		logic [3:0] hit;
		for (genvar o = 0; o < 4; o++) begin : g_other
			assign hit[o] = o != c && tx_active[o] && tx_highway_b[o] == tx_highway_b[c]
				&& tx_slot[o*SLOT_W +: SLOT_W] == tx_slot[c*SLOT_W +: SLOT_W];
		end
		assign coll[c] = tx_active[c] && |hit;
	end

	always_ff @(posedge mclk) begin
		if (clr) begin
			crash_a_ff <= 1'b0;
			crash_b_ff <= 1'b0;
			inhibit_ff <= 4'h0;
		end else if (ce) begin
			crash_a_ff <= |(coll & ~tx_highway_b);
			crash_b_ff <= |(coll & tx_highway_b);
			inhibit_ff <= coll;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign byte_out = byte_out_ff;
	assign xfer_busy = xfer_active_ff;
	assign bidir_signal_pin_out = pin_data_all;
	assign bidir_signal_pin_oe = pin_dir_all;
	assign irq_pair_low = irq_lo_ff;
	assign irq_pair_high = irq_hi_ff;
	assign slow_period_output = slow_ff;
	assign chopper_clock_output = chop_ff;
	assign tx_inhibit = inhibit_ff;
	assign mclk_select = mclk_sel_t'(common_ff[`XR5_MSEL_LSB+1:`XR5_MSEL_LSB]);

	for (genvar c = 0; c < 4; c++) begin : g_pcm
		assign pcm_double_clock[c] = pcm_cfg_ff[c][`XR6_CMODE_BIT];
		assign pcm_tx_falling[c] = pcm_cfg_ff[c][`XR6_XS_BIT];
		assign pcm_rx_rising[c] = pcm_cfg_ff[c][`XR6_RS_BIT];
		assign pcm_first_bit_half[c] = pcm_cfg_ff[c][`XR6_DRV0_BIT] && !pcm_cfg_ff[c][`XR6_CMODE_BIT];
		assign pcm_shift[c] = pcm_cfg_ff[c][`XR6_SHIFT_BIT] && pcm_cfg_ff[c][`XR6_CMODE_BIT];
		assign pcm_slot_offset[c*3 +: 3] = pcm_cfg_ff[c][`XR6_OFFS_LSB+2:`XR6_OFFS_LSB];
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_write_drives_pin: assert property (wr_en && xfer_idx_ff == `XR_IDX_PIN_DATA
		|=> bidir_signal_pin_out[7:0] == $past(byte_in)) else $error("pin data not driven");
	chk_read_input_level: assert property (rd_en && xfer_idx_ff == `XR_IDX_PIN_DATA && !pin_dir_ff[0]
		|=> byte_out[0] == $past(stable_ff[0])) else $error("input level not returned");
	chk_reset_inputs: assert property ($past(clr) |-> bidir_signal_pin_oe == 12'h000
		&& pcm_cfg_ff[0] == `XR_RESET) else $error("reset left pin driven");
	chk_third_dir_layout: assert property (wr_en && xfer_idx_ff == `XR_IDX_THIRD_PIN
		|=> bidir_signal_pin_oe[11:8] == $past(byte_in[3:0])) else $error("third pin layout wrong");
	chk_no_irq_disabled: assert property (ce && db_n == 4'h0 && !irq_pair_low
		|=> !irq_pair_low) else $error("interrupt while debounce off");
	chk_slow_fixed_high: assert property (ce && period_t == `PERIOD_HI_CODE
		|=> slow_period_output) else $error("slow output not high");
	chk_crash_flag_set: assert property (ce && tx_active[0] && tx_active[1] && !tx_highway_b[0]
		&& !tx_highway_b[1] && tx_slot[SLOT_W-1:0] == tx_slot[2*SLOT_W-1:SLOT_W]
		|=> crash_a_ff && tx_inhibit[0] && tx_inhibit[1]) else $error("collision missed");
	chk_version_field: assert property (rd_en && xfer_idx_ff == `XR_IDX_COMMON
		|=> byte_out[1:0] == VERSION_CODE) else $error("version field wrong");
	chk_drv0_single_only: assert property (pcm_first_bit_half[1] |-> !pcm_double_clock[1]
		##1 pcm_first_bit_half[1] || $changed(pcm_cfg_ff[1])) else $error("drive style in double mode");
	chk_irq_clear_read: assert property (ce && rd_clear && !(|accept) |=> !irq_pair_low && !irq_pair_high)
		else $error("interrupt not cleared");
	cov_write_pins: cover property (wr_en && xfer_idx_ff == `XR_IDX_PIN_DATA ##1 bidir_signal_pin_oe[0]);
	cov_irq_raise: cover property ($rose(irq_pair_low));
	cov_crash_b: cover property ($rose(crash_b_ff));
endmodule
`default_nettype wire

// >>> test/signaling_line_model.sv
// Line interface circuit model facing the bidirectional signaling pins
`default_nettype none
module signaling_line_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [11:0] pin_out,
	input wire logic [11:0] pin_oe,
	input wire logic [11:0] line_level,
	output logic [11:0] pin_in,
	output logic frame_sync
);
	timeunit 1ns;
	timeprecision 1ns;
	int frame_cnt;
	// ------------------------------------------------------------
	// Wire level and frame timing
	// ------------------------------------------------------------
	// Device drives command outputs, line circuit drives indications
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : line_level[i];
		end
	end
	// Frame sync counted from the master clock, 1250 cycles a frame
	always_ff @(posedge mclk) begin
		if (rst || frame_cnt == 1249) begin
			frame_cnt <= 0;
		end else begin
			frame_cnt <= frame_cnt + 1;
		end
		frame_sync <= (frame_cnt == 0);
	end
endmodule
`default_nettype wire

// >>> test/test_signaling_pin_pcm_config.sv
// Self-checking bench for the extended configuration registers
`default_nettype none
module test_signaling_pin_pcm_config;
	import sigpin_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [1:0] VER = 2'h3; // Arbitrary value
	logic mclk = 0, rst = 1, ce = 1, op_valid = 0, byte_strobe = 0, frame_sync, prev;
	logic [7:0] op_byte = 0, byte_in = 0, byte_out, rdv, pd, dir, th, db, cm, v;
	logic [7:0] pcm [4];
	logic [1:0] chan_addr = 0, coll;
	logic xfer_busy, irq_pair_low, irq_pair_high, slow_period_output, chopper_clock_output;
	logic [11:0] pin_in, pin_out, pin_oe, lvl = 0, pcm_slot_offset;
	logic [3:0] chan_powered = 0, tx_active = 0, tx_highway_b = 0, exp_inh, tx_inhibit;
	logic [3:0] pcm_double_clock, pcm_tx_falling, pcm_rx_rising, pcm_first_bit_half, pcm_shift;
	logic [27:0] tx_slot = 0;
	mclk_sel_t mclk_select;
	int fail_count = 0, checks = 0, n, e[5];
	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	signaling_pin_pcm_config #(.MS_DIV_1536(14'h000a), .MS_DIV_2048(14'h000e), .MS_DIV_4096(14'h0014),
		.MS_DIV_8192(14'h2000), .VERSION_CODE(VER)) dut (.mclk(mclk), .rst(rst), .ce(ce), .op_valid(op_valid),
		.op_byte(op_byte), .chan_addr(chan_addr), .byte_strobe(byte_strobe), .byte_in(byte_in),
		.byte_out(byte_out), .xfer_busy(xfer_busy), .bidir_signal_pin_in(pin_in), .bidir_signal_pin_out(pin_out),
		.bidir_signal_pin_oe(pin_oe), .irq_pair_low(irq_pair_low), .irq_pair_high(irq_pair_high),
		.slow_period_output(slow_period_output), .chopper_clock_output(chopper_clock_output),
		.chan_powered(chan_powered), .tx_active(tx_active), .tx_highway_b(tx_highway_b), .tx_slot(tx_slot),
		.tx_inhibit(tx_inhibit), .mclk_select(mclk_select), .pcm_double_clock(pcm_double_clock),
		.pcm_tx_falling(pcm_tx_falling), .pcm_rx_rising(pcm_rx_rising), .pcm_first_bit_half(pcm_first_bit_half),
		.pcm_shift(pcm_shift), .pcm_slot_offset(pcm_slot_offset));
	signaling_line_model line (.mclk(mclk), .rst(rst), .pin_out(pin_out), .pin_oe(pin_oe), .line_level(lvl),
		.pin_in(pin_in), .frame_sync(frame_sync));
	initial begin
		forever #50 mclk = ~mclk;
	end
	// ------------------------------------------------------------
	// Tasks and model
	// ------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_range(input string nm, input int lo, input int hi, input int got);
		checks++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge mclk);
	endtask
	task automatic wait_for(ref logic s, input logic val, output int cnt);
		cnt = 0;
		while (s !== val) begin
			tick(1);
			cnt++;
			if (cnt > 1000) begin
				fail_count++;
				final_report();
			end
		end
	endtask
	task automatic op(input logic [7:0] b, input logic [1:0] ch);
		op_byte = b;
		chan_addr = ch;
		op_valid = 1;
		tick(1);
		op_valid = 0;
	endtask
	task automatic wr(input logic [2:0] idx, input logic [7:0] val, input logic [1:0] ch);
		op({5'b00011, idx}, ch);
		byte_in = val;
		byte_strobe = 1;
		tick(1);
		byte_strobe = 0;
		tick(1);
		case (idx)
			3'h1: pd = val;
			3'h2: dir = val;
			3'h3: th = val;
			3'h4: db = val;
			3'h5: cm = val;
			3'h6: pcm[ch] = val;
			default: ;
		endcase
	endtask
	task automatic rd(input logic [2:0] idx, input logic [1:0] ch);
		op({5'b00111, idx}, ch);
		byte_strobe = 1;
		tick(1);
		byte_strobe = 0;
		rdv = byte_out;
	endtask
	function automatic logic [11:0] pin_exp();
		return ({th[7:4], pd} & {th[3:0], dir}) | (lvl & ~{th[3:0], dir});
	endfunction
	function automatic logic [7:0] exp_reg(input int idx, input int ch);
		case (idx)
			1: return pin_exp() & 12'h0ff;
			2: return dir;
			3: return {pin_exp() >> 8, th[3:0]};
			4: return db;
			5: return {cm[7:6], coll[0], coll[1], cm[3:2], VER};
			6: return pcm[ch];
			default: return 8'h00;
		endcase
	endfunction
	task automatic clear_model();
		{pd, dir, th, db, cm, coll} = 0;
		for (int c = 0; c < 4; c++) begin
			pcm[c] = 0;
		end
	endtask
	task automatic chk_regs(input int ch);
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0], ch[1:0]);
			chk("register readback", exp_reg(i, ch), rdv);
			chk("transfer busy", {11'h000, i != 0}, xfer_busy);
		end
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h63b0_5b35));
		clear_model();
		tick(2);
		rst = 0;
		chk("pin enables", 12'h000, pin_oe);
		chk("slow output", 12'h001, slow_period_output);
		chk("chopper output", 12'h001, chopper_clock_output);
		chk_regs(0);
		wr(3'h7, 8'hff, 0);
		chk_regs(1);
		// Pin direction, drive and readback
		for (int k = 0; k < 4; k++) begin
			lvl = 12'($urandom);
			wr(3'h2, 8'($urandom), 0);
			wr(3'h1, 8'($urandom), 1);
			wr(3'h3, 8'($urandom), 2);
			tick(3);
			chk("pin enables", {th[3:0], dir}, pin_oe);
			chk("pin drive", {th[7:4], pd} & pin_oe, pin_out & pin_oe);
			chk_regs(k);
		end
		// Debounce with glitch train, then a held change
		wr(3'h2, 8'h00, 0);
		wr(3'h3, 8'h00, 0);
		for (int k = 0; k < 2; k++) begin
			n = k ? 15 : 1;
			wr(3'h4, 8'(n << 4), 0);
			rd(3'h1, 0);
			rd(3'h3, 0);
			tick(2);
			repeat (8) begin
				lvl[4] = ~lvl[4];
				tick(6);
			end
			tick(n * 20 + 20);
			chk("pair high irq", 12'h000, irq_pair_high);
			lvl[0] = ~lvl[0];
			wait_for(irq_pair_low, 1'b1, e[0]);
			chk_range("debounce cycles", (2 * n - 1) * 10, (2 * n + 1) * 10 + 4, e[0]);
			rd(3'h1, 0);
			chk("register readback", exp_reg(1, 0), rdv);
			tick(1);
			chk("pair low irq", 12'h001, irq_pair_low);
			rd(3'h3, 0);
			tick(1);
			chk("pair low irq", 12'h000, irq_pair_low);
		end
		wr(3'h4, 8'h00, 0);
		lvl[2] = ~lvl[2];
		tick(60);
		chk("pair low irq", 12'h000, irq_pair_low);
		// Slow period output codes and clock selection
		wr(3'h4, 8'h0f, 0);
		tick(40);
		chk("slow output", 12'h000, slow_period_output);
		for (int k = 0; k < 2; k++) begin
			wr(3'h5, k ? 8'h40 : 8'h00, 2);
			tick(2);
			chk("clock select", k, mclk_select);
			wr(3'h4, 8'h03, 3);
			wait_for(slow_period_output, ~slow_period_output, e[0]);
			wait_for(slow_period_output, ~slow_period_output, e[0]);
			chk_range("slow half period", 3 * (k ? 14 : 10) - 1, 3 * (k ? 14 : 10) + 1, e[0]);
		end
		wr(3'h4, 8'h00, 0);
		// Chopper modes, last one with a channel powered
		for (int k = 0; k < 5; k++) begin
			wr(3'h5, {2'b11, 2'b00, 2'(k > 3 ? 3 : k), 2'h0}, 0);
			chan_powered = (k == 4) ? 4'h4 : 4'h0;
			tick(4);
			e[k] = 0;
			prev = chopper_clock_output;
			repeat (200) begin
				tick(1);
				if (prev === 1'b0 && chopper_clock_output === 1'b1) e[k]++;
				prev = chopper_clock_output;
			end
		end
		chk("chopper edges", 12'h000, e[0]);
		chk("chopper edges", 12'h000, e[3]);
		chk("chopper edges", 12'd100, e[4]);
		chk_range("chopper edges", 6, 7, e[2]);
		chk_range("chopper edges", 12, 13, e[1]);
		chk("clock select", 12'h003, mclk_select);
		chan_powered = 0;
		// Highway collisions
		for (int it = 0; it < 12; it++) begin
			tx_active = 4'($urandom);
			tx_highway_b = 4'($urandom);
			for (int c = 0; c < 4; c++) tx_slot[c * 7 +: 7] = 7'($urandom_range(2));
			exp_inh = 0;
			coll = 0;
			for (int i = 0; i < 4; i++) begin
				for (int j = 0; j < 4; j++) begin
					if (i != j && tx_active[i] && tx_active[j] && tx_highway_b[i] == tx_highway_b[j] &&
						tx_slot[i * 7 +: 7] == tx_slot[j * 7 +: 7]) begin
						exp_inh[i] = 1;
						coll[tx_highway_b[i]] = 1;
					end
				end
			end
			tick(2);
			chk("transmit inhibit", exp_inh, tx_inhibit);
			rd(3'h5, 0);
			chk("register readback", exp_reg(5, 0), rdv);
		end
		// PCM port options per channel, second round inverted
		for (int r = 0; r < 2; r++) begin
			for (int c = 0; c < 4; c++) begin
				v = r ? ~pcm[c] : 8'($urandom);
				if (r == 0 && c < 2) v[2:0] = c ? 3'h1 : 3'h7;
				wr(3'h6, v, c[1:0]);
			end
			tick(2);
			for (int c = 0; c < 4; c++) begin
				v = pcm[c];
				chk("double clock", v[7], pcm_double_clock[c]);
				chk("tx falling", v[6], pcm_tx_falling[c]);
				chk("rx rising", v[5], pcm_rx_rising[c]);
				chk("first bit half", v[4] & ~v[7], pcm_first_bit_half[c]);
				chk("shift", v[3] & v[7], pcm_shift[c]);
				chk("slot offset", v[2:0], pcm_slot_offset[c * 3 +: 3]);
				rd(3'h6, c[1:0]);
				chk("register readback", exp_reg(6, c), rdv);
			end
		end
		// Software reset
		tx_active = 0;
		wr(3'h2, 8'hff, 0);
		op(8'h98, 0);
		tick(2);
		clear_model();
		chk("pin enables", 12'h000, pin_oe);
		chk("slot offset", 12'h000, pcm_slot_offset);
		chk_regs(3);
		final_report();
	end
endmodule
`default_nettype wire
